// [include/slx_pkg.sv]
// Constants and carrier types for the serial link exchange state machine
package slx_pkg;
    // System clock
    localparam int CLK_PERIOD_NS = 10;
    // Nominal link timings
    localparam int HOLD_TIME_NS = 6400;
    localparam int WAIT_TIME_NS = 12800;
    localparam int DISC_TIME_NS = 850;
    // Least times round up, the disconnect limit rounds down
    localparam int HOLD_CYC = (HOLD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WAIT_CYC = (WAIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DISC_CYC = DISC_TIME_NS / CLK_PERIOD_NS;
    localparam int TMR_W = 11;
    localparam logic [TMR_W-1:0] HOLD_LAST = TMR_W'(HOLD_CYC - 1);
    localparam logic [TMR_W-1:0] WAIT_LAST = TMR_W'(WAIT_CYC - 1);
    localparam logic [6:0] DISC_LAST = 7'(DISC_CYC);
    // Received bits, oldest in the top bit
    localparam logic [6:0] NULL_PATTERN = 7'h74;
    localparam logic LINK_IDLE = 1'b0;
    // Flow control
    localparam logic [7:0] CREDIT_STEP = 8'h08;
    localparam logic [7:0] CREDIT_MAX  = 8'h38;
    localparam logic [2:0] GRANT_MAX   = 3'h7;
    // Register map
    localparam logic [7:0] CTRL_OFS  = 8'h00;
    localparam logic [7:0] STAT_OFS  = 8'h04;
    localparam logic [7:0] GRANT_OFS = 8'h08;
    localparam int CTRL_DIS_BIT   = 0;
    localparam int CTRL_START_BIT = 1;
    localparam int CTRL_AUTO_BIT  = 2;
    localparam logic [2:0] CTRL_RST = 3'h1;
    localparam int STAT_NULL_BIT = 3;
    localparam int STAT_ERR_LSB  = 4;
    // Sticky error flags
    localparam int ERR_CREDIT = 0;
    localparam int ERR_EMPTY  = 1;
    localparam int ERR_DISC   = 2;
    localparam int ERR_RX     = 3;

    typedef enum logic [2:0] {
        ST_RESET_HOLD, ST_RESET_WAIT, ST_READY, ST_STARTED, ST_CONN, ST_RUN
    } slx_state_t;

    typedef struct packed {
        logic fct;
        logic nChar;
        logic eop;
        logic parErr;
        logic escErr;
    } slx_rx_evt_t;

    typedef struct packed {
        logic en;
        logic fctOk;
        logic nCharOk;
    } slx_tx_ctl_t;
endpackage

// [design/slx_exchange_fsm.sv]
// Exchange-level link state machine with APB register access
// How it works
// - Normal character arriving with zero outstanding credit raises credit error.
// - EOP or EEP right after EOP or EEP raises empty packet error.
// - Auto-connect option starts the link once a NULL was received.
// - Enabled means not disabled and start, or auto-connect with NULL received.
// - Disable flag masks both start request and auto-connect.
// - Start request while enabled moves ready to started.
// - Reset-hold stops transmitter, then drops strobe, then data.
// - Reset-hold lasts 6.4 us, then reset-wait.
// - Reset-wait keeps transmitter off, receiver on; ready after 12.8 us.
// - Ready goes to started as soon as enabled.
// - Started sends NULLs; goes connecting once a NULL is received and one NULL was sent.
// - Started without NULL for 12.8 us returns to reset-hold.
// - Connecting sends FCTs and NULLs; an FCT received enters run.
// - Connecting without FCT for 12.8 us returns to reset-hold.
// - Disabled run passes hold, wait, ready and waits there.
// - No FCT is sent before a NULL was received.
// - NULL in reset-wait only sets the null-received flag.
// - With flag preset, started goes connecting after one NULL sent.
// - Run allows normal characters, FCTs and NULLs.
// - NULL detection runs in every state except reset-hold.
// - In run, disable or any receive error returns to reset-hold.
// - No data or strobe edge for 850 ns raises disconnect error.
// - Bit sequence 1110100 is a NULL and sets the flag.
`timescale 1ns/1ps
module slx_exchange_fsm
    import slx_pkg::*;
(
    // Clock, reset, clock enable
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        ce,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output      logic [31:0] prdata,
    output      logic        pready,
    output      logic        pslverr,
    // Link pins
    input  wire logic        linkDin,
    input  wire logic        linkSin,
    output      logic        linkDout,
    output      logic        linkSout,
    // Transmitter
    input  wire logic        txD,
    input  wire logic        txS,
    input  wire logic        txNullSent,
    input  wire logic        txFctSent,
    output      slx_tx_ctl_t txCtl,
    // Receiver
    input  wire slx_rx_evt_t rxEvt,
    output      logic        rxEnable,
    output      logic        linkRun
);
    slx_state_t       state;
    slx_state_t       next_state;
    logic [TMR_W-1:0] tmr;
    logic [2:0]       ctrl;
    logic [3:0]       errFlags;
    logic [7:0]       credit;
    logic [2:0]       pending;
    logic             nullReceivedFlag;
    logic             nullSent;
    logic             lastEop;
    logic             dMeta;
    logic             dSync;
    logic             dPrev;
    logic             sMeta;
    logic             sSync;
    logic             sPrev;
    logic [6:0]       rxShift;
    logic [6:0]       discCnt;
    logic             discArmed;
    logic             bitEvt;
    logic             nullDet;
    logic             discErr;
    logic             rxErr;
    logic             linkEnabled;
    logic             creditErr;
    logic             emptyErr;
    logic             nCharTake;
    logic             setup;
    logic             access;
    logic             mapped;
    logic             linkDisableFlag;
    logic             startRequest;
    logic             autoConnect;

    default clocking cb @(posedge clk iff ce);
    endclocking
    default disable iff (sys_rst);

    assign linkDisableFlag = ctrl[CTRL_DIS_BIT];
    assign startRequest    = ctrl[CTRL_START_BIT];
    assign autoConnect     = ctrl[CTRL_AUTO_BIT];

    // Pins come from another clock; two flops before any use
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            dMeta <= 1'b0;
            dSync <= 1'b0;
            dPrev <= 1'b0;
            sMeta <= 1'b0;
            sSync <= 1'b0;
            sPrev <= 1'b0;
        end else if (ce) begin
            dMeta <= linkDin;
            dSync <= dMeta;
            dPrev <= dSync;
            sMeta <= linkSin;
            sSync <= sMeta;
            sPrev <= sSync;
        end
    end

    // Every received bit toggles exactly one of data or strobe
    assign bitEvt = rxEnable && ((dSync ^ dPrev) || (sSync ^ sPrev));
    assign nullDet = bitEvt && ({rxShift[5:0], dSync} == NULL_PATTERN);

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rxShift <= 7'h00;
        end else if (ce) begin
            if (state == ST_RESET_HOLD) begin
                rxShift <= 7'h00;
            end else if (bitEvt) begin
                rxShift <= {rxShift[5:0], dSync};
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            nullReceivedFlag <= 1'b0;
        end else if (ce) begin
            if (state == ST_RESET_HOLD) begin
                nullReceivedFlag <= 1'b0;
            end else if (nullDet) begin
                nullReceivedFlag <= 1'b1;
            end
        end
    end

    // disconnect timer, armed by the first edge
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            discArmed <= 1'b0;
            discCnt   <= 7'h00;
        end else if (ce) begin
            if (state == ST_RESET_HOLD) begin
                discArmed <= 1'b0;
                discCnt   <= 7'h00;
            end else if (bitEvt) begin
                discArmed <= 1'b1;
                discCnt   <= 7'h00;
            end else if (discArmed && discCnt != DISC_LAST) begin
                discCnt <= discCnt + 7'h01;
            end
        end
    end

    assign discErr = discArmed && (discCnt == DISC_LAST);
    // Parity and escape checks only count once a NULL has been seen
    assign rxErr = discErr || (nullReceivedFlag && (rxEvt.parErr || rxEvt.escErr));
    assign linkEnabled = !linkDisableFlag &&
        (startRequest || (autoConnect && nullReceivedFlag));
    assign nCharTake = (state == ST_RUN) && rxEvt.nChar;
    assign creditErr = nCharTake && (credit == 8'h00);
    assign emptyErr = nCharTake && rxEvt.eop && lastEop;

    // state timer on the system clock
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            tmr <= '0;
        end else if (ce) begin
            if (next_state != state) begin
                tmr <= '0;
            end else if (tmr != '1) begin
                tmr <= tmr + TMR_W'(1);
            end
        end
    end

    always_comb begin
        next_state = state;
        unique case (state)
            ST_RESET_HOLD: begin
                if (tmr == HOLD_LAST) begin
                    next_state = ST_RESET_WAIT;
                end
            end
            ST_RESET_WAIT: begin
                // wait time; NULL alone changes nothing
                if (rxErr || (nullReceivedFlag && rxEvt.fct)) begin
                    next_state = ST_RESET_HOLD;
                end else if (tmr == WAIT_LAST) begin
                    next_state = ST_READY;
                end
            end
            ST_READY: begin
                if (rxErr || (nullReceivedFlag && (rxEvt.fct || rxEvt.nChar))) begin
                    next_state = ST_RESET_HOLD;
                end else if (linkEnabled) begin
                    next_state = ST_STARTED;
                end
            end
            ST_STARTED: begin
                // timeout; NULL seen and one sent
                if (rxErr || tmr == WAIT_LAST ||
                    (nullReceivedFlag && (rxEvt.fct || rxEvt.nChar))) begin
                    next_state = ST_RESET_HOLD;
                end else if (nullReceivedFlag && nullSent) begin
                    next_state = ST_CONN;
                end
            end
            ST_CONN: begin
                if (rxErr || rxEvt.nChar || tmr == WAIT_LAST) begin
                    next_state = ST_RESET_HOLD;
                end else if (rxEvt.fct) begin
                    next_state = ST_RUN;
                end
            end
            ST_RUN: begin
                // disable or error; reset sequence follows
                if (linkDisableFlag || rxErr || creditErr || emptyErr) begin
                    next_state = ST_RESET_HOLD;
                end
            end
            // Unused codes fall back to the safe state
            default: begin
                next_state = ST_RESET_HOLD;
            end
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state <= ST_RESET_HOLD;
        end else if (ce) begin
            state <= next_state;
        end
    end

    // At least one NULL must be handed to the transmitter in started
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            nullSent <= 1'b0;
        end else if (ce) begin
            if (state != ST_STARTED) begin
                nullSent <= 1'b0;
            end else if (txNullSent) begin
                nullSent <= 1'b1;
            end
        end
    end

    // Credit: each FCT sent promises eight more characters
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            credit  <= 8'h00;
            pending <= 3'h0;
            lastEop <= 1'b0;
        end else if (ce) begin
            if (state == ST_RESET_HOLD) begin
                credit  <= 8'h00;
                pending <= 3'h0;
                lastEop <= 1'b0;
            end else begin
                credit <= credit
                    + ((txFctSent && txCtl.fctOk) ? CREDIT_STEP : 8'h00)
                    - ((nCharTake && credit != 8'h00) ? 8'h01 : 8'h00);
                pending <= pending
                    + ((access && pwrite && paddr == GRANT_OFS &&
                        pending != GRANT_MAX) ? 3'h1 : 3'h0)
                    - ((txFctSent && pending != 3'h0) ? 3'h1 : 3'h0);
                if (nCharTake) begin
                    lastEop <= rxEvt.eop;
                end
            end
        end
    end

    // Registered controls seen by transmitter and receiver
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            txCtl    <= '0;
            rxEnable <= 1'b0;
            linkRun  <= 1'b0;
        end else if (ce) begin
            txCtl.en <= next_state inside {ST_STARTED, ST_CONN, ST_RUN};
            // FCT only after a NULL; credit capped
            txCtl.fctOk <= (next_state inside {ST_CONN, ST_RUN}) &&
                nullReceivedFlag && pending != 3'h0 &&
                credit <= CREDIT_MAX - CREDIT_STEP;
            txCtl.nCharOk <= next_state == ST_RUN;
            rxEnable <= next_state != ST_RESET_HOLD;
            linkRun  <= next_state == ST_RUN;
        end
    end

    // stop, then strobe, then data, never together
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            linkDout <= LINK_IDLE;
            linkSout <= LINK_IDLE;
        end else if (ce) begin
            if (state == ST_RESET_HOLD) begin
                if (tmr == TMR_W'(1)) begin
                    linkSout <= LINK_IDLE;
                end else if (tmr > TMR_W'(1)) begin
                    linkDout <= LINK_IDLE;
                    linkSout <= LINK_IDLE;
                end
            end else if (txCtl.en) begin
                linkDout <= txD;
                linkSout <= txS;
            end
        end
    end

    // APB: zero wait states, answer prepared in the setup cycle
    assign setup  = psel && !penable;
    assign access = psel && penable && pready;
    assign mapped = paddr == CTRL_OFS || paddr == STAT_OFS || paddr == GRANT_OFS;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
        end else if (ce) begin
            pready  <= setup;
            pslverr <= setup && !mapped;
            if (setup) begin
                unique case (paddr)
                    CTRL_OFS:  prdata <= {29'h0, ctrl};
                    STAT_OFS:  prdata <= {24'h0, errFlags, nullReceivedFlag, state};
                    GRANT_OFS: prdata <= {16'h0, credit, 5'h0, pending};
                    default:   prdata <= 32'h0;
                endcase
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl <= CTRL_RST;
        end else if (ce && access && pwrite && paddr == CTRL_OFS) begin
            ctrl <= pwdata[2:0];
        end
    end

    // Sticky errors, write one to clear; a new error wins over the clear
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            errFlags <= 4'h0;
        end else if (ce) begin
            for (int i = 0; i < 4; i++) begin
                if (access && pwrite && paddr == STAT_OFS && pwdata[STAT_ERR_LSB + i]) begin
                    errFlags[i] <= 1'b0;
                end
            end
            if (creditErr) begin
                errFlags[ERR_CREDIT] <= 1'b1;
            end
            if (emptyErr) begin
                errFlags[ERR_EMPTY] <= 1'b1;
            end
            if (discErr) begin
                errFlags[ERR_DISC] <= 1'b1;
            end
            if (rxErr && !discErr) begin
                errFlags[ERR_RX] <= 1'b1;
            end
        end
    end

    sequence s_holdEntry;
        $rose(state == ST_RESET_HOLD);
    endsequence

    sequence s_pinOrder;
        ##1 $stable({linkDout, linkSout}) ##1 (linkSout == LINK_IDLE && $stable(linkDout))
        ##1 (linkSout == LINK_IDLE && linkDout == LINK_IDLE);
    endsequence

    property p_pinOrder;
        s_holdEntry |-> s_pinOrder;
    endproperty
    a_pinOrder: assert property (p_pinOrder) else $error("pin reset order wrong");

    property p_holdTime;
        $rose(state == ST_RESET_WAIT) |-> $past(state) == ST_RESET_HOLD && $past(tmr) == HOLD_LAST;
    endproperty
    a_holdTime: assert property (p_holdTime) else $error("reset-hold time wrong");

    property p_waitTime;
        $rose(state == ST_READY) |-> $past(tmr) == WAIT_LAST && !txCtl.en;
    endproperty
    a_waitTime: assert property (p_waitTime) else $error("reset-wait time wrong");

    property p_enable;
        state == ST_READY && linkEnabled && !rxErr && !rxEvt.fct && !rxEvt.nChar
            |=> state == ST_STARTED && txCtl.en;
    endproperty
    a_enable: assert property (p_enable) else $error("ready did not start");

    property p_disabled;
        state == ST_READY && linkDisableFlag |=> state != ST_STARTED;
    endproperty
    a_disabled: assert property (p_disabled) else $error("started while disabled");

    property p_startTmo;
        state == ST_STARTED && tmr == WAIT_LAST |=> state == ST_RESET_HOLD;
    endproperty
    a_startTmo: assert property (p_startTmo) else $error("started timeout missed");

    property p_connTmo;
        state == ST_CONN && tmr == WAIT_LAST |=> state == ST_RESET_HOLD;
    endproperty
    a_connTmo: assert property (p_connTmo) else $error("connecting timeout missed");

    property p_fctGate;
        txCtl.fctOk |-> nullReceivedFlag && linkRun || state == ST_CONN;
    endproperty
    a_fctGate: assert property (p_fctGate) else $error("FCT allowed too early");

    property p_credit;
        creditErr |=> state == ST_RESET_HOLD && errFlags[ERR_CREDIT];
    endproperty
    a_credit: assert property (p_credit) else $error("credit error missed");

    property p_empty;
        emptyErr |=> state == ST_RESET_HOLD && errFlags[ERR_EMPTY];
    endproperty
    a_empty: assert property (p_empty) else $error("empty packet missed");

    property p_waitNull;
        state == ST_RESET_WAIT && nullDet && !rxErr && tmr != WAIT_LAST
            |=> state == ST_RESET_WAIT && nullReceivedFlag;
    endproperty
    a_waitNull: assert property (p_waitNull) else $error("NULL in wait misbehaved");
endmodule

// [bench/slx_peer_model.sv]
// Far-end link model sending NULLs with data-strobe encoding
`timescale 1ns/1ps
module slx_peer_model
(
    // Clock and control
    input  wire logic clk,
    input  wire logic sendOn,
    // Link lines towards the block
    output      logic linkD,
    output      logic linkS
);
    // NULL code repeated
    // Bits leave oldest first; the pattern 1110100 lies inside each word
    localparam logic [7:0] NULL_WORD = 8'he8;
    logic [2:0] bitIx = 3'h0;
    logic [2:0] div   = 3'h0;
    logic       nd;

    initial begin
        linkD = 1'b0;
        linkS = 1'b0;
    end

    // One bit per 80 ns; lines stand still while sending is off
    always @(posedge clk) begin
        if (sendOn) begin
            div <= div + 3'h1;
            if (div == 3'h7) begin
                nd = NULL_WORD[3'h7 - bitIx];
                // Strobe toggles when data repeats, so exactly one line moves
                if (nd == linkD) begin
                    linkS <= ~linkS;
                end
                linkD <= nd;
                bitIx <= bitIx + 3'h1;
            end
        end
    end
endmodule

// [bench/tb.sv]
// Self-checking bench for the exchange state machine
`timescale 1ns/1ps
module tb;
    import slx_pkg::*;
    logic        clk;
    logic        sys_rst;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        linkDin;
    logic        linkSin;
    logic        txD;
    logic        txS;
    logic        txNullSent;
    logic        txFctSent;
    slx_tx_ctl_t txCtl;
    slx_rx_evt_t rxEvt;
    logic        rxEnable;
    logic        linkRun;
    logic        linkDout;
    logic        linkSout;
    logic        peerOn;
    logic [64:0] expQ[$];
    int          fails = 0;
    int          tests_run = 0;
    int          cycles = 0;
    int          relT;
    int          n;

    slx_exchange_fsm i_slx_exchange_fsm (.clk(clk), .sys_rst(sys_rst), .ce(1'b1),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .linkDin(linkDin),
        .linkSin(linkSin), .linkDout(linkDout), .linkSout(linkSout), .txD(txD), .txS(txS),
        .txNullSent(txNullSent), .txFctSent(txFctSent), .txCtl(txCtl), .rxEvt(rxEvt),
        .rxEnable(rxEnable), .linkRun(linkRun));
    slx_peer_model i_slx_peer_model (.clk(clk), .sendOn(peerOn), .linkD(linkDin),
        .linkS(linkSin));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic test_done();
        $display("Comparisons %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        @(negedge clk);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %0t level got %b expected %b", $time, got, exp);
        end
    endtask

    // Note holds {slave error, mask, masked data}
    task automatic chk_apb(input logic [31:0] got, input logic gotErr, input logic [64:0] note);
        tests_run++;
        if ((got & note[63:32]) !== note[31:0] || gotErr !== note[64]) begin
            fails++;
            $display("ERROR %0t read got %h expected %h", $time, got, note[31:0]);
        end
    endtask

    // Request held until the edge that samples pready high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [31:0] m = 32'h0, input logic e = 1'b0);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        if (!w) begin
            expQ.push_back({e, m, d & m});
        end
        @(posedge clk);
        penable <= 1'b1;
        @(negedge clk);
        while (pready !== 1'b1) @(negedge clk);
        @(posedge clk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Read data taken at the edge that samples pready high
    always @(posedge clk) begin
        if (psel && penable && pready === 1'b1 && !pwrite && expQ.size() > 0) begin
            chk_apb(prdata, pslverr, expQ.pop_front());
        end
    end

    // Bits: {null sent, fct sent, fct, nChar, eop, parity, escape}
    task automatic pulse(input logic [6:0] p);
        @(posedge clk);
        {txNullSent, txFctSent, rxEvt} <= p;
        @(posedge clk);
        {txNullSent, txFctSent, rxEvt} <= 7'h0;
        @(negedge clk);
    endtask

    task automatic wait_en(input int lim);
        n = 0;
        while (txCtl.en !== 1'b1 && n < lim) begin
            @(negedge clk);
            n++;
        end
        chk_bit(txCtl.en, 1'b1);
    endtask

    task automatic to_run();
        wait_en(2500);
        apb(1'b0, STAT_OFS, 32'h3, 32'h7);
        pulse(7'h40);
        apb(1'b0, STAT_OFS, 32'h4, 32'h7);
        apb(1'b1, GRANT_OFS, $urandom);
        // Grant lands at the access edge, the FCT permit one edge later
        repeat (2) @(negedge clk);
        chk_bit(txCtl.fctOk, 1'b1);
        pulse(7'h20);
        pulse(7'h10);
        chk_bit(linkRun, 1'b1);
        chk_bit(txCtl.nCharOk, 1'b1);
    endtask

    // Transmitter bits are random; they only reach the pins while enabled
    always @(posedge clk) begin
        txD <= 1'($urandom);
        txS <= 1'($urandom);
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fails++;
            $display("ERROR %0t run did not finish", $time);
            test_done();
        end
    end

    initial begin
        void'($urandom(32'hf5fd91c3));
        sys_rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        txD = 1'b0;
        txS = 1'b0;
        txNullSent = 1'b0;
        txFctSent = 1'b0;
        rxEvt = 5'h00;
        peerOn = 1'b0;
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        @(negedge clk);
        relT = cycles;
        apb(1'b0, CTRL_OFS, 32'h1, 32'h7);
        apb(1'b0, 8'hfc, 32'h0, 32'hffffffff, 1'b1);
        while (rxEnable !== 1'b1 && cycles - relT < 2000) @(negedge clk);
        chk_bit((cycles - relT) inside {[638:642]}, 1'b1);
        @(posedge clk);
        peerOn <= 1'b1;
        repeat (200) @(posedge clk);
        apb(1'b0, STAT_OFS, 32'h9, 32'hf);
        repeat (1150) @(posedge clk);
        apb(1'b0, STAT_OFS, 32'ha, 32'hf);
        apb(1'b1, CTRL_OFS, 32'h7);
        repeat (20) @(posedge clk);
        chk_bit(txCtl.en, 1'b0);
        apb(1'b0, STAT_OFS, 32'ha, 32'hf);
        apb(1'b1, CTRL_OFS, 32'h2);
        to_run();
        apb(1'b0, GRANT_OFS, 32'h0800, 32'hff07);
        repeat (8) pulse(7'h08);
        chk_bit(linkRun, 1'b1);
        pulse(7'h08);
        chk_bit(linkRun, 1'b0);
        apb(1'b0, STAT_OFS, 32'h10, 32'h17);
        @(negedge clk);
        chk_bit(linkSout, LINK_IDLE);
        chk_bit(linkDout, LINK_IDLE);
        // Second attempt: auto-connect, then let connecting time out
        apb(1'b1, STAT_OFS, 32'hf0);
        apb(1'b1, CTRL_OFS, 32'h4);
        apb(1'b0, STAT_OFS, 32'h0, 32'hf0);
        wait_en(2500);
        pulse(7'h40);
        repeat (1200) @(posedge clk);
        chk_bit(rxEnable, 1'b1);
        repeat (100) @(posedge clk);
        chk_bit(rxEnable, 1'b0);
        // Started with a NULL seen but none sent must time out
        wait_en(2500);
        repeat (1300) @(negedge clk);
        chk_bit(rxEnable, 1'b0);
        // Third attempt: two end markers in a row
        apb(1'b1, CTRL_OFS, 32'h2);
        to_run();
        pulse(7'h0c);
        pulse(7'h0c);
        apb(1'b0, STAT_OFS, 32'h20, 32'h37);
        // Fourth attempt: disabled in run, parks in ready
        to_run();
        apb(1'b1, CTRL_OFS, 32'h1);
        repeat (2) @(negedge clk);
        chk_bit(linkRun, 1'b0);
        repeat (2000) @(negedge clk);
        apb(1'b0, STAT_OFS, 32'ha, 32'hf);
        chk_bit(txCtl.en, 1'b0);
        // Fifth attempt: far end goes silent
        apb(1'b1, CTRL_OFS, 32'h2);
        to_run();
        @(posedge clk);
        peerOn <= 1'b0;
        repeat (60) @(posedge clk);
        chk_bit(linkRun, 1'b1);
        repeat (60) @(posedge clk);
        chk_bit(linkRun, 1'b0);
        apb(1'b0, STAT_OFS, 32'h40, 32'h47);
        test_done();
    end
endmodule
